// >>> design/asr_host.sv
// Host controller that drives an asynchronous 8K x 8 static memory
`timescale 1ns/1ns
`default_nettype none

module asr_host
	import asr_pkg::*;
#(
	parameter int GRADE = 0 // 0 fastest, 1 middle, 2 slowest
) (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              nrst,
	// User request
	input  wire logic              req_valid,
	input  wire logic              req_write,
	input  wire logic [ADDR_W-1:0] req_addr,
	input  wire logic [DATA_W-1:0] req_wdata,
	output logic                   req_ready,
	// User read answer
	output logic                   rsp_valid,
	output logic [DATA_W-1:0]      rsp_rdata,
	// Retention control
	input  wire logic              ret_req,
	output logic                   ret_ack,
	// Memory pins
	output logic                   select_active_low,
	output logic                   select_active_high,
	output logic                   enable_n,
	output logic                   strobe_n,
	output logic [ADDR_W-1:0]      mem_addr,
	input  wire logic [DATA_W-1:0] dq_i,
	output logic [DATA_W-1:0]      dq_o,
	output logic                   dq_oe
);

	// ****************************************************************
	// Cycle counts for the chosen grade
	// ****************************************************************
	localparam int ACC_I    = cyc_ceil(ADDR_ACCESS_MAX_NS[GRADE]);
	localparam int RCYC_I   = max2(ACC_I, cyc_ceil(READ_CYCLE_MIN_NS[GRADE]));
	localparam int STRB_I   = max2(max2(cyc_ceil(STROBE_PULSE_MIN_NS[GRADE]),
		cyc_ceil(DATA_OVERLAP_MIN_NS[GRADE])),
		max2(cyc_ceil(SELECT_TO_STORE_END_NS[GRADE]),
		cyc_ceil(ADDR_TO_STORE_END_NS[GRADE])) - 1);
	localparam int END_I    = max2(1, cyc_ceil(STORE_CYCLE_MIN_NS[GRADE]) - 1 - STRB_I);
	localparam logic [CNT_W-1:0] C_ACCESS = CNT_W'(RCYC_I);
	localparam logic [CNT_W-1:0] C_STROBE = CNT_W'(STRB_I);
	localparam logic [CNT_W-1:0] C_END    = CNT_W'(END_I);
	localparam logic [CNT_W-1:0] C_FLOAT  = CNT_W'(cyc_ceil(ENABLE_FLOAT_MAX_NS[GRADE]));
	localparam logic [CNT_W-1:0] C_RECOV  = CNT_W'(cyc_ceil(READ_CYCLE_MIN_NS[GRADE]));
	localparam logic [CNT_W-1:0] C_PULSE  = CNT_W'(cyc_ceil(STROBE_PULSE_MIN_NS[GRADE]));
	localparam logic [CNT_W-1:0] C_SELEND = CNT_W'(cyc_ceil(SELECT_TO_STORE_END_NS[GRADE]));
	localparam logic [CNT_W-1:0] C_DATA   = CNT_W'(cyc_ceil(DATA_OVERLAP_MIN_NS[GRADE]));
	localparam logic [CNT_W-1:0] C_STORE  = CNT_W'(cyc_ceil(STORE_CYCLE_MIN_NS[GRADE]));

	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		asr_state_t        st;
		logic              sel_n;
		logic              sel_h;
		logic              oe_n;
		logic              we_n;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] dq_o;
		logic              dq_oe;
		logic              ready;
		logic              rsp_valid;
		logic [DATA_W-1:0] rdata;
		logic              ret_ack;
		logic [CNT_W-1:0]  float_cnt; // cycles enable has been high
		logic [CNT_W-1:0]  wlo_cnt;   // cycles strobe has been low
		logic [CNT_W-1:0]  sel_cnt;   // cycles both selects active
		logic [CNT_W-1:0]  olo_cnt;   // cycles enable has been low
		logic [CNT_W-1:0]  since_ret; // cycles since retention ended
	} asr_host_state_t;

	asr_host_state_t  s;
	asr_host_state_t  n;
	logic             tm_load;
	logic [CNT_W-1:0] tm_val;
	logic             tm_done;

	asr_tmr #(.W(CNT_W)) i_asr_tmr (
		.clk      (clk),
		.nrst     (nrst),
		.load     (tm_load),
		.load_val (tm_val),
		.done     (tm_done)
	);

	// ****************************************************************
	// Next state
	// ****************************************************************
	// Phase lengths are loaded minus one so a phase spans exactly its count
	always_comb begin
		n           = s;
		n.rsp_valid = 1'b0;
		tm_load     = 1'b0;
		tm_val      = '0;
		n.float_cnt = s.oe_n ? sat_inc(s.float_cnt) : '0;
		n.wlo_cnt   = s.we_n ? '0 : sat_inc(s.wlo_cnt);
		n.sel_cnt   = (!s.sel_n && s.sel_h) ? sat_inc(s.sel_cnt) : '0;
		n.olo_cnt   = s.oe_n ? '0 : sat_inc(s.olo_cnt);
		n.since_ret = s.ret_ack ? '0 : sat_inc(s.since_ret);
		unique case (s.st)
			ST_IDLE: begin
				if (req_valid && s.ready) begin
					n.ready = 1'b0;
					n.addr  = req_addr;
					n.sel_n = 1'b0;
					n.sel_h = 1'b1;
					if (req_write) begin
						n.dq_o = req_wdata;
						n.st   = ST_WSETUP;
					end else begin
						n.oe_n  = 1'b0;
						n.st    = ST_READ;
						tm_load = 1'b1;
						tm_val  = C_ACCESS - 1'b1;
					end
				end else if (ret_req) begin
					// Selects are already off in idle, so retention is granted without a deselect
					n.ready   = 1'b0;
					n.ret_ack = 1'b1;
					n.st      = ST_RET;
				end else begin
					n.ready = 1'b1;
				end
			end
			ST_READ: begin
				if (tm_done) begin
					n.rdata     = dq_i;
					n.rsp_valid = 1'b1;
					n.oe_n      = 1'b1;
					n.sel_n     = 1'b1;
					n.sel_h     = 1'b0;
					n.st        = ST_IDLE;
				end
			end
			ST_WSETUP: begin
				// Wait for a previous read to float before driving
				if (s.float_cnt >= C_FLOAT) begin
					n.we_n  = 1'b0;
					n.dq_oe = 1'b1;
					n.st    = ST_WSTROBE;
					tm_load = 1'b1;
					tm_val  = C_STROBE - 1'b1;
				end
			end
			ST_WSTROBE: begin
				if (tm_done) begin
					n.we_n  = 1'b1;
					n.st    = ST_WEND;
					tm_load = 1'b1;
					tm_val  = C_END - 1'b1;
				end
			end
			ST_WEND: begin
				// Data and address held one more phase: zero hold is met with margin
				if (tm_done) begin
					n.dq_oe = 1'b0;
					n.sel_n = 1'b1;
					n.sel_h = 1'b0;
					n.st    = ST_IDLE;
				end
			end
			ST_RET: begin
				// High-active select stays low so other pins may float
				if (!ret_req) begin
					n.ret_ack = 1'b0;
					n.st      = ST_RECOV;
					tm_load   = 1'b1;
					tm_val    = C_RECOV - 1'b1;
				end
			end
			ST_RECOV: begin
				if (tm_done) begin
					n.ready = 1'b1;
					n.st    = ST_IDLE;
				end
			end
			default: begin
				n.st = ST_IDLE;
			end
		endcase
	end

	// Idle: deselected, no drive, float counter saturated so a first write may go
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s           <= '0;
			s.st        <= ST_IDLE;
			s.sel_n     <= 1'b1;
			s.oe_n      <= 1'b1;
			s.we_n      <= 1'b1;
			s.float_cnt <= {CNT_W{1'b1}};
			s.since_ret <= {CNT_W{1'b1}};
		end else begin
			s <= n;
		end
	end

	// Outputs straight from the state register
	assign req_ready          = s.ready;
	assign rsp_valid          = s.rsp_valid;
	assign rsp_rdata          = s.rdata;
	assign ret_ack            = s.ret_ack;
	assign select_active_low  = s.sel_n;
	assign select_active_high = s.sel_h;
	assign enable_n           = s.oe_n;
	assign strobe_n           = s.we_n;
	assign mem_addr           = s.addr;
	assign dq_o               = s.dq_o;
	assign dq_oe              = s.dq_oe;

	// ****************************************************************
	// Checks
	// ****************************************************************
	property p_sel_in_write;
		@(posedge clk) disable iff (!nrst) !s.we_n |-> (!s.sel_n && s.sel_h);
	endproperty
	a_sel_in_write: assert property (p_sel_in_write)
		else $error("strobe low without both selects");

	property p_strobe_min;
		@(posedge clk) disable iff (!nrst) $rose(s.we_n) |-> s.wlo_cnt >= C_PULSE;
	endproperty
	a_strobe_min: assert property (p_strobe_min)
		else $error("strobe pulse too short");

	property p_sel_to_end;
		@(posedge clk) disable iff (!nrst) $rose(s.we_n) |-> s.sel_cnt >= C_SELEND;
	endproperty
	a_sel_to_end: assert property (p_sel_to_end)
		else $error("selects not active long enough before write end");

	property p_addr_steady;
		@(posedge clk) disable iff (!nrst) (!s.we_n || $rose(s.we_n)) |-> $stable(s.addr);
	endproperty
	a_addr_steady: assert property (p_addr_steady)
		else $error("address moved during write");

	property p_data_setup;
		@(posedge clk) disable iff (!nrst)
			$rose(s.we_n) |-> (s.dq_oe && $stable(s.dq_o) && s.wlo_cnt >= C_DATA);
	endproperty
	a_data_setup: assert property (p_data_setup)
		else $error("write data not set up before write end");

	property p_no_fight;
		@(posedge clk) disable iff (!nrst) s.dq_oe |-> (s.oe_n && s.float_cnt >= C_FLOAT);
	endproperty
	a_no_fight: assert property (p_no_fight)
		else $error("host drives data while memory may drive");

	property p_read_access;
		@(posedge clk) disable iff (!nrst) $rose(s.rsp_valid) |-> s.olo_cnt >= C_ACCESS;
	endproperty
	a_read_access: assert property (p_read_access)
		else $error("read data sampled before access time");

	property p_cycle_min;
		@(posedge clk) disable iff (!nrst) $fell(s.sel_h) |-> s.sel_cnt >= C_STORE;
	endproperty
	a_cycle_min: assert property (p_cycle_min)
		else $error("access cycle shorter than minimum");

	property p_ret_desel;
		@(posedge clk) disable iff (!nrst) s.ret_ack |-> (!s.sel_h && s.sel_n && s.dq_oe == 1'b0);
	endproperty
	a_ret_desel: assert property (p_ret_desel)
		else $error("memory selected during retention");

	property p_recovery;
		@(posedge clk) disable iff (!nrst) $rose(s.sel_h) |-> s.since_ret >= C_RECOV;
	endproperty
	a_recovery: assert property (p_recovery)
		else $error("access started before retention recovery");

endmodule : asr_host

`default_nettype wire

// >>> design/asr_pkg.sv
// Shared constants, timing tables and helpers for the static memory host controller
`default_nettype none

package asr_pkg;

	// ****************************************************************
	// Geometry and clock
	// ****************************************************************
	localparam int ADDR_W = 13;
	localparam int DATA_W = 8;
	localparam int CNT_W  = 4;
	localparam int CLK_NS = 20;
	localparam int GRADES = 3;

	// ****************************************************************
	// Timing per speed grade in ns, fastest grade first
	// ****************************************************************
	localparam int READ_CYCLE_MIN_NS[GRADES]       = '{100, 120, 150};
	localparam int ADDR_ACCESS_MAX_NS[GRADES]      = '{100, 120, 150};
	localparam int ENABLE_FLOAT_MAX_NS[GRADES]     = '{35, 40, 50};
	localparam int STORE_CYCLE_MIN_NS[GRADES]      = '{100, 120, 150};
	localparam int STROBE_PULSE_MIN_NS[GRADES]     = '{60, 70, 90};
	localparam int SELECT_TO_STORE_END_NS[GRADES]  = '{80, 85, 100};
	localparam int ADDR_TO_STORE_END_NS[GRADES]    = '{80, 85, 100};
	localparam int DATA_OVERLAP_MIN_NS[GRADES]     = '{40, 40, 50};
	localparam int DESELECT_TO_RETENTION_NS        = 0;

	// ****************************************************************
	// Controller states
	// ****************************************************************
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_READ,
		ST_WSETUP,
		ST_WSTROBE,
		ST_WEND,
		ST_RET,
		ST_RECOV
	} asr_state_t;

	// Least time to whole cycles, never below one
	function automatic int cyc_ceil(input int ns);
		int c;
		c = (ns + CLK_NS - 1) / CLK_NS;
		return (c < 1) ? 1 : c;
	endfunction : cyc_ceil

	function automatic int max2(input int a, input int b);
		return (a > b) ? a : b;
	endfunction : max2

	// Saturating count, keeps helper counters from wrapping
	function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
		return (v == {CNT_W{1'b1}}) ? v : v + 1'b1;
	endfunction : sat_inc

endpackage : asr_pkg

`default_nettype wire

// >>> design/asr_tmr.sv
// Down counter that times the phases of a memory access
`timescale 1ns/1ns
`default_nettype none

module asr_tmr
	import asr_pkg::*;
#(
	parameter int W = CNT_W
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         nrst,
	// Control
	input  wire logic         load,
	input  wire logic [W-1:0] load_val,
	// Status
	output logic              done
);

	typedef struct packed {
		logic [W-1:0] cnt;
	} asr_tmr_state_t;

	asr_tmr_state_t s_q;
	asr_tmr_state_t s_d;

	// Load wins over counting; stops at zero
	always_comb begin
		s_d = s_q;
		if (load) begin
			s_d.cnt = load_val;
		end else if (s_q.cnt != '0) begin
			s_d.cnt = s_q.cnt - 1'b1;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign done = (s_q.cnt == '0);

endmodule : asr_tmr

`default_nettype wire

// >>> test/asr_sram_model.sv
// Behavioural static memory that answers the host controller's pins
`timescale 1ns/1ns
`default_nettype none

module asr_sram_model
	import asr_pkg::*;
#(
	parameter int GRADE  = 0,
	parameter int ACC_NS = 90, // Answer delay, inside the access maximum
	parameter int DRV_NS = 10, // Earliest drive after select or enable
	parameter int FLT_NS = 8   // Float delay, kept below DRV_NS
) (
	// Memory pins
	input  wire logic              select_active_low,
	input  wire logic              select_active_high,
	input  wire logic              enable_n,
	input  wire logic              strobe_n,
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [DATA_W-1:0] dq,
	// Device half of the data pins
	output logic                   drv,
	output logic [DATA_W-1:0]      dout,
	// Host timing faults seen
	output int                     n_viol
);
	logic [DATA_W-1:0] mem [1 << ADDR_W];
	realtime           t_ws, t_sel, t_a, t_d;
	bit                wr_seen; // A write really began since the last end
	wire logic sel   = !select_active_low && select_active_high;
	wire logic rd_on = sel && strobe_n && !enable_n;
	wire logic wr_on = sel && !strobe_n;

	task automatic flag(input string m);
		$display("[FAIL] %0t %s", $time, m);
		n_viol++;
	endtask : flag

	initial begin
		drv = 1'b0;
		dout = '0;
		n_viol = 0;
		t_ws = -1000;
	end

	// ****************************************************************
	// Read side; garbage after the hold time so stale data is not read
	// ****************************************************************
	always @(rd_on, addr) begin
		if (!rd_on) begin
			drv <= #FLT_NS 1'b0;
		end else begin
			drv  <= #DRV_NS 1'b1;
			dout <= #10 ~mem[addr];
			dout <= #ACC_NS mem[addr];
		end
	end

	// ****************************************************************
	// Write side and host timing checks
	// ****************************************************************
	always @(addr) t_a = $realtime;
	always @(dq) t_d = $realtime;
	always @(posedge sel) t_sel = $realtime;

	always @(posedge wr_on) begin
		if ($realtime - t_ws < STORE_CYCLE_MIN_NS[GRADE]) flag("store cycle short");
		t_ws = $realtime;
		wr_seen = 1'b1;
	end

	// Data taken at the first release of the write
	// The unknown-to-low step at reset is no write end, so it is skipped
	always @(negedge wr_on) begin
		if (wr_seen) begin
			wr_seen = 1'b0;
			mem[addr] = dq;
			if ($realtime - t_ws < STROBE_PULSE_MIN_NS[GRADE]) flag("strobe short");
			if ($realtime - t_sel < SELECT_TO_STORE_END_NS[GRADE]) flag("select short");
			if ($realtime - t_a < ADDR_TO_STORE_END_NS[GRADE]) flag("address late");
			if (t_a > t_ws) flag("address moved in write");
			if ($realtime - t_d < DATA_OVERLAP_MIN_NS[GRADE]) flag("data late");
		end
	end

endmodule : asr_sram_model

`default_nettype wire

// >>> test/asr_host_test.sv
// Self-checking bench for the static memory host controller
`timescale 1ns/1ns
`default_nettype none

module asr_host_test;
	import asr_pkg::*;

	logic              clk, nrst, req_valid, req_write, req_ready, rsp_valid;
	logic              ret_req, ret_ack, rdy_s, drv, dq_oe;
	logic              select_active_low, select_active_high, enable_n, strobe_n;
	logic [ADDR_W-1:0] req_addr, mem_addr;
	logic [DATA_W-1:0] req_wdata, rsp_rdata, dq_o, dout, dq_i;
	int                num_errors, n_checks, n_viol;
	logic [ADDR_W-1:0] addrs [3] = '{13'h0000, 13'h1FFF, 13'h0AAA};
	logic [DATA_W-1:0] datas [3] = '{8'hA5, 8'h5A, 8'h3C};

	// Floating pins show the inverse so a stale value never passes
	assign dq_i = dq_oe ? dq_o : (drv ? dout : ~dout);

	asr_host #(.GRADE(0)) i_asr_host (.clk(clk), .nrst(nrst), .req_valid(req_valid),
		.req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
		.req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
		.ret_req(ret_req), .ret_ack(ret_ack), .select_active_low(select_active_low),
		.select_active_high(select_active_high), .enable_n(enable_n), .strobe_n(strobe_n),
		.mem_addr(mem_addr), .dq_i(dq_i), .dq_o(dq_o), .dq_oe(dq_oe));

	asr_sram_model #(.GRADE(0)) i_asr_sram_model (.select_active_low(select_active_low),
		.select_active_high(select_active_high), .enable_n(enable_n), .strobe_n(strobe_n),
		.addr(mem_addr), .dq(dq_i), .drv(drv), .dout(dout), .n_viol(n_viol));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// Mid-cycle copy of ready, so the take edge is judged without a race
	always @(negedge clk) rdy_s <= req_ready;

	// Host and device never drive the data pins together
	always @(negedge clk) if (dq_oe === 1'b1 && drv === 1'b1) fail("bus fight");

	task automatic fail(input string m);
		$display("[FAIL] %0t %s", $time, m);
		num_errors++;
	endtask : fail

	task automatic chk(input logic ok, input string m);
		n_checks++;
		if (ok !== 1'b1) fail(m);
	endtask : chk

	task automatic put(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge clk);
		req_valid <= 1'b1;
		req_write <= w;
		req_addr  <= a;
		req_wdata <= d;
	endtask : put

	task automatic wait_taken;
		int k;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (rdy_s !== 1'b1 && k < 50);
		req_valid <= 1'b0;
	endtask : wait_taken

	// Read answer must come in the sixth cycle after the take
	task automatic rd_done(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
		int i;
		wait_taken;
		for (i = 1; i < 9; i++) begin
			@(negedge clk);
			if (i == 1) chk(!select_active_low && select_active_high && !enable_n && strobe_n
				&& mem_addr === a, "read pins");
			if (rsp_valid === 1'b1) break;
		end
		chk(i == 6, "read latency");
		chk(rsp_rdata === exp, "read data");
	endtask : rd_done

	task automatic do_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		int k, lo;
		put(1'b1, a, d);
		wait_taken;
		lo = 0;
		// Judge mid-cycle only: at the take edge ready still shows its old value
		for (k = 0; k < 20; k++) begin
			@(negedge clk);
			if (req_ready === 1'b1) break;
			if (strobe_n === 1'b0) begin
				lo++;
				chk(dq_oe && dq_o === d && mem_addr === a && !select_active_low
					&& select_active_high, "write pins");
			end
		end
		chk(lo == 3, "strobe width");
	endtask : do_write

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic t_reset;
		@(negedge clk);
		chk(select_active_low && !select_active_high && enable_n && strobe_n && !dq_oe
			&& req_ready === 1'b0, "reset pins");
	endtask : t_reset

	// Write then read at once, both ends of the address range and one address between
	task automatic t_back_to_back;
		for (int i = 0; i < 3; i++) begin
			do_write(addrs[i], datas[i]);
			put(1'b0, addrs[i], 8'h00);
			rd_done(addrs[i], datas[i]);
		end
	endtask : t_back_to_back

	// Requests refused while held; data kept through retention
	task automatic t_retention;
		int n;
		@(posedge clk);
		ret_req <= 1'b1;
		repeat (2) @(negedge clk);
		chk(ret_ack === 1'b1 && select_active_high === 1'b0, "retention entry");
		put(1'b0, addrs[1], 8'h00);
		repeat (3) @(negedge clk);
		chk(req_ready === 1'b0 && ret_ack === 1'b1, "retention refuse");
		@(posedge clk);
		ret_req <= 1'b0;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (req_ready !== 1'b1 && n < 20);
		chk(n == 7, "recovery time");
		rd_done(addrs[1], datas[1]);
		put(1'b0, addrs[0], 8'h00);
		rd_done(addrs[0], datas[0]);
	endtask : t_retention

	task automatic give_verdict;
		num_errors += n_viol;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : give_verdict

	initial begin
		#60000;
		num_errors++;
		give_verdict;
	end

	initial begin
		nrst = 1'b0;
		req_valid = 1'b0;
		req_write = 1'b0;
		req_addr = '0;
		req_wdata = '0;
		ret_req = 1'b0;
		num_errors = 0;
		n_checks = 0;
		t_reset;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		t_back_to_back;
		t_retention;
		repeat (4) @(posedge clk);
		give_verdict;
	end

endmodule : asr_host_test

`default_nettype wire
